// ### verilog/lhc_pkg.sv
// Package for the host controller upper flag bank of a serial link core.
// Assumes a byte-addressed register port with 32-bit data words.
package lhc_pkg;

    localparam int LHC_ADDR_W = 8;
    localparam int LHC_DATA_W = 32;

    // Register byte addresses.
    localparam logic [7:0] LHC_OFS_CTL_SET = 8'h50;
    localparam logic [7:0] LHC_OFS_CTL_CLR = 8'h54;
    localparam logic [7:0] LHC_OFS_EVENT   = 8'h80;
    localparam logic [7:0] LHC_OFS_MASK    = 8'h88;

    // Bit positions of the control flags.
    localparam int LHC_BIT_ROM_VALID = 31;
    localparam int LHC_BIT_SWAP_DIS  = 30;
    localparam int LHC_BIT_TARDY     = 29;
    localparam int LHC_BIT_OWNER     = 23;
    localparam int LHC_BIT_PHY_ON    = 22;
    localparam int LHC_BIT_LPS       = 19;
    localparam int LHC_BIT_POSTED    = 18;
    localparam int LHC_BIT_LINK_EN   = 17;
    localparam int LHC_BIT_SOFT_RST  = 16;

    // Flags that software may both set and clear.
    localparam logic [31:0] LHC_RSC_MASK  = 32'hE04E_0000;
    localparam logic [31:0] LHC_CTL_RESET = 32'h0000_0000;
    localparam logic        LHC_OWNER_DEF = 1'h1;

    // Event bits of the interrupt status register.
    localparam int          LHC_EV_TARDY     = 27;
    localparam int          LHC_EV_FETCH_ERR = 0;
    localparam logic [31:0] LHC_EV_MASK      = 32'h0800_0001;
    localparam logic [31:0] LHC_ZERO         = 32'h0000_0000;

    // Acknowledge codes sent back to a remote node.
    localparam logic [3:0] LHC_ACK_PENDING    = 4'h2;
    localparam logic [3:0] LHC_ACK_TARDY      = 4'hB;
    localparam logic [3:0] LHC_ACK_TYPE_ERROR = 4'hE;
    localparam logic [3:0] LHC_ACK_NONE       = 4'h0;

    // Duration of a software reset in clock cycles.
    localparam int         LHC_SRST_CYCLES = 8;
    localparam logic [3:0] LHC_SRST_LAST   = 4'(LHC_SRST_CYCLES - 1);
    localparam logic [3:0] LHC_SRST_ZERO   = 4'h0;

    typedef struct packed {
        logic rom_read;   // block read aimed at host configuration ROM
        logic async_req;  // any other asynchronous packet to this node
        logic bus_reset;  // bus reset seen on the serial bus
        logic fetch_err;  // fetch error while loading bus info registers
    } lhc_rx_s;

    typedef struct packed {
        logic       valid;
        logic [3:0] code;
    } lhc_ack_s;

endpackage : lhc_pkg

// ### verilog/lhc_flags.sv
// Upper flag bank of the host controller control set/clear register pair,
// with the acknowledge decisions and interrupt events that those flags steer.
// Assumes a register port sampled on i_sys_clk, one-cycle event pulses from
// the receive path, and synchronous active-low resets on the same clock.
`timescale 1ns/1ps
module lhc_flags
    import lhc_pkg::*;
(
    // Clock and resets
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_resetn,
    input  wire logic                  i_global_reset_pin_n,
    // Register port
    input  wire logic [LHC_ADDR_W-1:0] i_addr,
    input  wire logic [LHC_DATA_W-1:0] i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic      [LHC_DATA_W-1:0] o_rdata,
    // Interrupt
    output logic                       o_irq,
    // Serial EEPROM loader
    input  wire logic                  i_eeprom_load,
    input  wire logic                  i_eeprom_owner,
    // Receive path events and acknowledge answer
    input  wire lhc_rx_s               i_rx,
    output lhc_ack_s                   o_ack,
    // Control outputs toward the link core
    output logic                       o_rom_update_en,
    output logic                       o_rom_shadow_load,
    output logic                       o_dma_swap_en,
    output logic                       o_link_active,
    output logic                       o_phy_enhance_on,
    output logic                       o_phy_enhance_owner,
    output logic                       o_link_power_on,
    output logic                       o_posted_write_en,
    output logic                       o_soft_reset
);

    logic [31:0] ctl_reg;
    logic [31:0] ctl_next;
    logic        owner_reg;
    logic        srst_reg;
    logic [3:0]  srst_cnt_reg;
    logic [31:0] event_reg;
    logic [31:0] event_next;
    logic [31:0] mask_reg;
    logic        tardy_sent;
    logic        wr_set;
    logic        wr_clr;
    logic        wr_event;
    logic        wr_mask;
    logic        hw_reset;
    logic        srst_start;
    logic        srst_done;
    logic [31:0] ctl_view;
    logic [31:0] rdata_next;
    lhc_ack_s    ack_next;

    // The global reset pin is a superset of the hardware reset.
    assign hw_reset = !i_resetn || !i_global_reset_pin_n;

    // Address decode of the register port.
    always_comb begin
        wr_set   = 1'b0;
        wr_clr   = 1'b0;
        wr_event = 1'b0;
        wr_mask  = 1'b0;
        if (i_wr && (i_addr == LHC_OFS_CTL_SET)) begin
            wr_set = 1'b1;
        end else if (i_wr && (i_addr == LHC_OFS_CTL_CLR)) begin
            wr_clr = 1'b1;
        end else if (i_wr && (i_addr == LHC_OFS_EVENT)) begin
            wr_event = 1'b1;
        end else if (i_wr && (i_addr == LHC_OFS_MASK)) begin
            wr_mask = 1'b1;
        end
    end

    // A software reset starts on a one written to the soft reset bit at the
    // set address; writing it while one is running does not restart it.
    assign srst_start = wr_set && i_wdata[LHC_BIT_SOFT_RST] && !srst_reg;
    assign srst_done  = srst_reg && (srst_cnt_reg == LHC_SRST_LAST);

    always_ff @(posedge i_sys_clk) begin
        if (hw_reset) begin
            srst_reg     <= 1'b0;
            srst_cnt_reg <= LHC_SRST_ZERO;
        end else if (srst_start) begin
            srst_reg     <= 1'b1;
            srst_cnt_reg <= LHC_SRST_ZERO;
        end else if (srst_done) begin
            srst_reg     <= 1'b0;
            srst_cnt_reg <= LHC_SRST_ZERO;
        end else if (srst_reg) begin
            srst_cnt_reg <= srst_cnt_reg + 4'h1;
        end
    end

    // Control flags. Only the set/clear flags are stored; every other bit
    // of the word is built at read time, so the reserved bits cannot drift from zero.
    always_comb begin
        ctl_next = ctl_reg;
        if (srst_start || srst_reg) begin
            ctl_next = LHC_CTL_RESET;
        end else begin
            if (wr_set) begin
                ctl_next |= i_wdata & LHC_RSC_MASK;
            end
            if (wr_clr) begin
                ctl_next &= ~(i_wdata & LHC_RSC_MASK);
            end
            // Losing the bus info image makes the ROM image untrustworthy.
            if (i_rx.fetch_err) begin
                ctl_next[LHC_BIT_ROM_VALID] = 1'b0;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (hw_reset) begin
            ctl_reg <= LHC_CTL_RESET;
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    // Ownership flag: only the global reset pin returns it to its default,
    // and the EEPROM loader overwrites it after that.
    always_ff @(posedge i_sys_clk) begin
        if (!i_global_reset_pin_n) begin
            owner_reg <= LHC_OWNER_DEF;
        end else if (i_eeprom_load) begin
            owner_reg <= i_eeprom_owner;
        end
    end

    // The pin copy follows the same resets as the flag itself, so a
    // hardware or software reset never makes the ownership seem to change.
    always_ff @(posedge i_sys_clk) begin
        if (!i_global_reset_pin_n) begin
            o_phy_enhance_owner <= LHC_OWNER_DEF;
        end else if (i_eeprom_load) begin
            o_phy_enhance_owner <= i_eeprom_owner;
        end
    end

    // Word seen at either address of the pair.
    always_comb begin
        ctl_view                   = ctl_reg & LHC_RSC_MASK;
        ctl_view[LHC_BIT_OWNER]    = owner_reg;
        ctl_view[LHC_BIT_SOFT_RST] = srst_reg;
    end

    // Acknowledge decision. With the connection enable low nothing is
    // answered at all, so remote nodes see the device as absent.
    always_comb begin
        ack_next.valid = 1'b0;
        ack_next.code  = LHC_ACK_NONE;
        tardy_sent     = 1'b0;
        if (!ctl_reg[LHC_BIT_LINK_EN]) begin
            ack_next.valid = 1'b0;
        end else if (i_rx.rom_read) begin
            ack_next.valid = 1'b1;
            if (ctl_reg[LHC_BIT_ROM_VALID]) begin
                ack_next.code = LHC_ACK_PENDING;
            end else begin
                ack_next.code = LHC_ACK_TYPE_ERROR;
            end
        end else if (i_rx.async_req && ctl_reg[LHC_BIT_TARDY]) begin
            ack_next.valid = 1'b1;
            ack_next.code  = LHC_ACK_TARDY;
            tardy_sent     = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (hw_reset || srst_reg) begin
            o_ack <= '0;
        end else begin
            o_ack <= ack_next;
        end
    end

    // Interrupt events. A new event wins over a write-one clear in the
    // same cycle so that no tardy answer goes unreported.
    always_comb begin
        event_next = event_reg;
        if (wr_event) begin
            event_next = event_next & ~(i_wdata & LHC_EV_MASK);
        end
        if (tardy_sent) begin
            event_next[LHC_EV_TARDY] = 1'b1;
        end
        if (i_rx.fetch_err) begin
            event_next[LHC_EV_FETCH_ERR] = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (hw_reset || srst_reg) begin
            event_reg <= LHC_ZERO;
        end else begin
            event_reg <= event_next;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (hw_reset || srst_reg) begin
            mask_reg <= LHC_ZERO;
        end else if (wr_mask) begin
            mask_reg <= i_wdata & LHC_EV_MASK;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (hw_reset) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(event_next & mask_reg);
        end
    end

    // Read data, valid only in the cycle after the read strobe.
    always_comb begin
        rdata_next = LHC_ZERO;
        if (i_rd && (i_addr == LHC_OFS_CTL_SET)) begin
            rdata_next = ctl_view;
        end else if (i_rd && (i_addr == LHC_OFS_CTL_CLR)) begin
            rdata_next = ctl_view;
        end else if (i_rd && (i_addr == LHC_OFS_EVENT)) begin
            rdata_next = event_reg;
        end else if (i_rd && (i_addr == LHC_OFS_MASK)) begin
            rdata_next = mask_reg;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (hw_reset) begin
            o_rdata <= LHC_ZERO;
        end else begin
            o_rdata <= rdata_next;
        end
    end

    // The ROM header, map and bus options shadows reload at a bus reset
    // only while the image is marked valid; otherwise they keep old values.
    always_ff @(posedge i_sys_clk) begin
        if (hw_reset) begin
            o_rom_shadow_load <= 1'b0;
        end else begin
            o_rom_shadow_load <= i_rx.bus_reset
                                 && ctl_reg[LHC_BIT_ROM_VALID];
        end
    end

    // Registered copies of the flags for the link core. They are taken from
    // the next value so that each copy changes at the same edge as its flag, except the swap enable around a hardware reset.
    always_ff @(posedge i_sys_clk) begin
        if (hw_reset) begin
            o_rom_update_en <= 1'b0;
        end else begin
            o_rom_update_en <= ctl_next[LHC_BIT_ROM_VALID];
        end
    end

    // Swapping is on while the disable flag is low, so it reads as on
    // from the first edge after reset.
    always_ff @(posedge i_sys_clk) begin
        if (hw_reset) begin
            o_dma_swap_en <= 1'b0;
        end else begin
            o_dma_swap_en <= !ctl_next[LHC_BIT_SWAP_DIS];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (hw_reset) begin
            o_link_active <= 1'b0;
        end else begin
            o_link_active <= ctl_next[LHC_BIT_LINK_EN];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (hw_reset) begin
            o_phy_enhance_on <= 1'b0;
        end else begin
            o_phy_enhance_on <= ctl_next[LHC_BIT_PHY_ON];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (hw_reset) begin
            o_link_power_on <= 1'b0;
        end else begin
            o_link_power_on <= ctl_next[LHC_BIT_LPS];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (hw_reset) begin
            o_posted_write_en <= 1'b0;
        end else begin
            o_posted_write_en <= ctl_next[LHC_BIT_POSTED];
        end
    end

    // High from the edge that takes the request until the counter ends,
    // matching the soft reset bit that software reads.
    always_ff @(posedge i_sys_clk) begin
        if (hw_reset) begin
            o_soft_reset <= 1'b0;
        end else begin
            o_soft_reset <= srst_start || (srst_reg && !srst_done);
        end
    end

endmodule : lhc_flags

// ### dv/lhc_flags_asserts.sv
// Concurrent checks on the ports of the upper host control flag bank.
// Assumes it is bound into lhc_flags and watches only that module's ports.
`timescale 1ns/1ps
module lhc_flags_asserts
    import lhc_pkg::*;
(
    input wire logic                  i_sys_clk,
    input wire logic                  i_resetn,
    input wire logic                  i_global_reset_pin_n,
    input wire logic [LHC_ADDR_W-1:0] i_addr,
    input wire logic [LHC_DATA_W-1:0] i_wdata,
    input wire logic                  i_wr,
    input wire logic                  i_rd,
    input wire logic [LHC_DATA_W-1:0] o_rdata,
    input wire logic                  i_eeprom_load,
    input wire lhc_rx_s               i_rx,
    input wire lhc_ack_s              o_ack,
    input wire logic                  o_rom_update_en,
    input wire logic                  o_rom_shadow_load,
    input wire logic                  o_dma_swap_en,
    input wire logic                  o_link_active,
    input wire logic                  o_phy_enhance_owner,
    input wire logic                  o_soft_reset
);
    logic rst_n;
    assign rst_n = i_resetn & i_global_reset_pin_n;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!rst_n);

    reserved_bits_zero_a: assert property (i_rd && (i_addr == LHC_OFS_CTL_SET
        || i_addr == LHC_OFS_CTL_CLR) |=> o_rdata[28:24] == 5'h00)
        else $error("reserved bits read nonzero");
    rom_ok_a: assert property (i_rx.rom_read && o_link_active
        && o_rom_update_en && !o_soft_reset
        |=> o_ack.valid && o_ack.code == LHC_ACK_PENDING)
        else $error("ROM read not accepted");
    type_err_a: assert property (i_rx.rom_read && o_link_active
        && !o_rom_update_en && !o_soft_reset
        |=> o_ack.valid && o_ack.code == LHC_ACK_TYPE_ERROR)
        else $error("ROM read not refused");
    link_off_a: assert property (!o_link_active |=> !o_ack.valid)
        else $error("answer while disconnected");
    fetch_clr_a: assert property (i_rx.fetch_err |=> !o_rom_update_en)
        else $error("fetch error kept ROM valid");
    hw_clr_a: assert property (disable iff (1'b0) !i_resetn
        |=> !o_rom_update_en && !o_link_active)
        else $error("reset kept flags");
    swap_set_a: assert property (i_wr && i_addr == LHC_OFS_CTL_SET
        && i_wdata[30] && !i_wdata[16] && !o_soft_reset |=> !o_dma_swap_en)
        else $error("swap disable not set");
    link_clr_a: assert property (i_wr && i_addr == LHC_OFS_CTL_CLR
        && i_wdata[17] |=> !o_link_active)
        else $error("clear write ignored");
    shadow_hold_a: assert property (i_rx.bus_reset && !o_rom_update_en
        |=> !o_rom_shadow_load)
        else $error("shadow load while ROM invalid");
    owner_def_a: assert property (disable iff (1'b0)
        !i_global_reset_pin_n |=> o_phy_enhance_owner)
        else $error("owner not defaulted");
    owner_keep_a: assert property (disable iff (1'b0)
        i_global_reset_pin_n && !i_eeprom_load
        |=> $stable(o_phy_enhance_owner))
        else $error("owner changed");
    cover property (o_ack.valid && o_ack.code == LHC_ACK_TARDY);
    cover property (o_ack.valid && o_ack.code == LHC_ACK_TYPE_ERROR);
    cover property (o_rom_shadow_load);
endmodule : lhc_flags_asserts

bind lhc_flags lhc_flags_asserts u_chk (.*);

// ### dv/lhc_node_model.sv
// Remote node model: sends one packet per request and keeps the answer.
// Assumes the bench raises i_send for one cycle per packet.
`timescale 1ns/1ps
module lhc_node_model
    import lhc_pkg::*;
(
    // Clock
    input  wire logic     i_sys_clk,
    // Bench request
    input  wire logic     i_send,
    input  wire lhc_rx_s  i_pkt,
    // Link side
    input  wire lhc_ack_s i_ack,
    output lhc_rx_s       o_rx = '0,
    output lhc_ack_s      o_seen = '0
);
    logic pend_reg = 1'b0;
    // The answer is taken one cycle after the packet, even when none comes.
    always @(posedge i_sys_clk) begin
        o_rx <= i_send ? i_pkt : '0;
        pend_reg <= (o_rx != '0);
        if (pend_reg) o_seen <= i_ack;
    end
endmodule : lhc_node_model

// ### dv/lhc_flags_tb.sv
// Self-checking bench for the upper host control flag bank.
// Assumes the checker is bound separately and a remote node model exists.
`timescale 1ns/1ps
module lhc_flags_tb;
    import lhc_pkg::*;
    logic        i_sys_clk = 1'b0, i_resetn = 1'b0;
    logic        i_global_reset_pin_n = 1'b0;
    logic [7:0]  i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0, o_rdata, v, d, fl;
    logic        i_wr = 1'b0, i_rd = 1'b0, i_eeprom_load = 1'b0;
    logic        i_eeprom_owner = 1'b1, own, o_irq, send = 1'b0;
    logic        o_rom_update_en, o_rom_shadow_load, o_dma_swap_en;
    logic        o_link_active, o_phy_enhance_on, o_link_power_on;
    logic        o_posted_write_en, o_soft_reset, o_phy_enhance_owner;
    logic [3:0]  pkt = 4'h0;
    lhc_rx_s     i_rx;
    lhc_ack_s    o_ack, a;
    int          n_fail = 0, checks = 0, nsh = 0;

    lhc_flags dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
        .i_global_reset_pin_n(i_global_reset_pin_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_irq(o_irq), .i_eeprom_load(i_eeprom_load),
        .i_eeprom_owner(i_eeprom_owner), .i_rx(i_rx), .o_ack(o_ack),
        .o_rom_update_en(o_rom_update_en),
        .o_rom_shadow_load(o_rom_shadow_load), .o_dma_swap_en(o_dma_swap_en),
        .o_link_active(o_link_active), .o_phy_enhance_on(o_phy_enhance_on),
        .o_phy_enhance_owner(o_phy_enhance_owner),
        .o_link_power_on(o_link_power_on),
        .o_posted_write_en(o_posted_write_en), .o_soft_reset(o_soft_reset));
    lhc_node_model node (.i_sys_clk(i_sys_clk), .i_send(send), .i_pkt(pkt),
        .i_ack(o_ack), .o_rx(i_rx), .o_seen(a));

    initial begin
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) if (o_rom_shadow_load) nsh++;

    function automatic logic [31:0] ectl();
        return fl | {8'h00, own, 23'h0};
    endfunction : ectl
    task automatic chk(input string nm, input logic [31:0] s, e);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
        @(posedge i_sys_clk);
        i_addr <= ad;
        i_wdata <= dt;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] ad);
        @(posedge i_sys_clk);
        i_addr <= ad;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask : rd
    task automatic tx(input logic [3:0] p);
        @(posedge i_sys_clk);
        send <= 1'b1;
        pkt <= p;
        @(posedge i_sys_clk);
        send <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        #1;
    endtask : tx
    task automatic results();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results

    initial begin
        #200000;
        n_fail++;
        results();
    end
    initial begin
        void'($urandom(99));
        repeat (10) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        i_global_reset_pin_n <= 1'b1;
        own = 1'b1;
        fl = 32'h0;
        rd(LHC_OFS_CTL_CLR);
        chk("ctl", v, 32'h0080_0000);
        rd(8'h60);
        chk("unmapped", v, 32'h0);
        for (int i = 0; i < 24; i++) begin
            d = $urandom & 32'h7FFE_FFFF;
            if (!fl[17] || !own) d[22] = 1'b0;
            wr(i[0] ? LHC_OFS_CTL_CLR : LHC_OFS_CTL_SET, d);
            if (i[0]) fl = fl & ~(d & LHC_RSC_MASK);
            else fl = fl | (d & LHC_RSC_MASK);
            rd(i[1] ? LHC_OFS_CTL_CLR : LHC_OFS_CTL_SET);
            chk("ctl", v, ectl());
            chk("swap", 32'(o_dma_swap_en), 32'(!fl[30]));
            chk("phy_on", 32'(o_phy_enhance_on), 32'(fl[22]));
            chk("lps", 32'(o_link_power_on), 32'(fl[19]));
            chk("posted", 32'(o_posted_write_en), 32'(fl[18]));
            chk("link", 32'(o_link_active), 32'(fl[17]));
        end
        wr(LHC_OFS_CTL_CLR, 32'hFFFE_FFFF);
        wr(LHC_OFS_CTL_SET, 32'h0002_0000);
        tx(4'h8);
        chk("ack", 32'(a), {27'h0, 1'b1, LHC_ACK_TYPE_ERROR});
        wr(LHC_OFS_CTL_CLR, 32'h0002_0000);
        wr(LHC_OFS_CTL_SET, 32'h8000_0000);
        wr(LHC_OFS_CTL_SET, 32'h2002_0000);
        wr(LHC_OFS_MASK, 32'h0800_0000);
        tx(4'h8);
        chk("ack", 32'(a), {27'h0, 1'b1, LHC_ACK_PENDING});
        tx(4'h4);
        chk("ack", 32'(a), {27'h0, 1'b1, LHC_ACK_TARDY});
        chk("irq", 32'(o_irq), 32'h1);
        rd(LHC_OFS_EVENT);
        chk("event", v, 32'h0800_0000);
        wr(LHC_OFS_EVENT, 32'h0800_0000);
        rd(LHC_OFS_EVENT);
        chk("event", v, 32'h0);
        chk("irq", 32'(o_irq), 32'h0);
        tx(4'h2);
        chk("shadow", 32'(nsh), 32'h1);
        tx(4'h1);
        chk("romvalid", 32'(o_rom_update_en), 32'h0);
        tx(4'h2);
        chk("shadow", 32'(nsh), 32'h1);
        wr(LHC_OFS_CTL_CLR, 32'h0002_0000);
        tx(4'h4);
        chk("ackvalid", 32'(a.valid), 32'h0);
        wr(LHC_OFS_CTL_SET, 32'h8000_0000);
        wr(LHC_OFS_CTL_SET, 32'h0001_0000);
        #1 chk("srst", 32'(o_soft_reset), 32'h1);
        repeat (10) @(posedge i_sys_clk);
        chk("srst", 32'(o_soft_reset), 32'h0);
        fl = 32'h0;
        rd(LHC_OFS_CTL_SET);
        chk("ctl", v, ectl());
        @(posedge i_sys_clk);
        i_eeprom_owner <= 1'b0;
        i_eeprom_load <= 1'b1;
        @(posedge i_sys_clk);
        i_eeprom_load <= 1'b0;
        own = 1'b0;
        wr(LHC_OFS_CTL_SET, 32'h0080_0000);
        rd(LHC_OFS_CTL_SET);
        chk("ctl", v, ectl());
        chk("owner", 32'(o_phy_enhance_owner), 32'(own));
        @(posedge i_sys_clk);
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        rd(LHC_OFS_CTL_SET);
        chk("ctl", v, ectl());
        chk("owner", 32'(o_phy_enhance_owner), 32'(own));
        @(posedge i_sys_clk);
        i_global_reset_pin_n <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_global_reset_pin_n <= 1'b1;
        own = 1'b1;
        rd(LHC_OFS_CTL_SET);
        chk("ctl", v, ectl());
        chk("owner", 32'(o_phy_enhance_owner), 32'(own));
        results();
    end
endmodule : lhc_flags_tb
